/* fsf_flags.sv */
/*
  Fault and status flags of the general interrupt status register (bits 8 to 2) and config state.
  Assumes async detector levels and one-cycle status read and config write strobes.
*/
// Function
// - amp overvoltage flag at bit 8 follows out-of-range on input five or six
// - while that flag is high the affected analog inputs are disconnected
// - bit 7 is one while main high supply difference is under threshold
// - bit 6 is one while output high supply difference is under threshold
// - thermal shutdown detector sets thermal shutdown flag at bit 5
// - thermal shutdown resets config and channel control, keeping crc and refs
// - reading the status register clears the thermal shutdown flag
// - thermal warning at bit 4 rises above 145C, falls below 135C only
// - overcurrent detector sets overcurrent flag at bit 3
// - automatic clear mode drops overcurrent flag once the condition ends
// - host clear mode keeps overcurrent flag until a status read
// - output mode write of 0x9 to 0xf sets config error flag at bit 2
// - pair mode write of 0x5 to 0x7 is an error; rejected fields keep value
// - illegal mode code error clears on status read
// - output mode needing unpowered amps: error, power them up, clear on read
// - diag selection needing unpowered amps: error until the conflict is gone
module fsf_flags (
  input  wire logic        clk,
  input  wire logic        rst,
  // detector levels, asynchronous
  input  wire logic        ovv_input_five,
  input  wire logic        ovv_input_six,
  input  wire logic        main_supply_uv,
  input  wire logic        output_supply_uv,
  input  wire logic        therm_shdn_det,
  input  wire logic        therm_above_warn,
  input  wire logic        therm_below_release,
  input  wire logic        overcurrent_det,
  // status register read
  input  wire logic        status_rd,
  output logic [23:0]      status_rdata,
  // configuration write
  input  wire logic        cfg_wr,
  input  wire logic [3:0]  wr_output_mode_code,
  input  wire logic [2:0]  wr_input_pair_a_mode_code,
  input  wire logic [2:0]  wr_input_pair_b_mode_code,
  input  wire logic [5:0]  wr_amp_power,
  input  wire logic [2:0]  wr_diag_channel_select,
  input  wire logic        wr_overcurrent_clear_mode,
  input  wire logic        wr_crc_enable,
  input  wire logic        wr_output_converter_ref_select,
  input  wire logic        wr_input_converter_ref_select,
  input  wire logic        chan_wr,
  input  wire logic [7:0]  wr_channel_control,
  // configuration state
  output logic [3:0]       output_mode_code,
  output logic [2:0]       input_pair_a_mode_code,
  output logic [2:0]       input_pair_b_mode_code,
  output logic [5:0]       amp_power,
  output logic [2:0]       diag_channel_select,
  output logic             overcurrent_clear_mode,
  output logic             crc_enable,
  output logic             output_converter_ref_select,
  output logic             input_converter_ref_select,
  output logic [7:0]       channel_control_register,
  output logic             input_five_disconnect,
  output logic             input_six_disconnect
);

  // ==========================================================================
  // helpers
  // ==========================================================================
  function automatic logic out_mode_bad(input logic [3:0] code);
    out_mode_bad = (code >= fsf_pkg::OUT_MODE_BAD_LO) && (code <= fsf_pkg::OUT_MODE_BAD_HI);
  endfunction : out_mode_bad

  function automatic logic pair_mode_bad(input logic [2:0] code);
    pair_mode_bad = (code >= fsf_pkg::PAIR_MODE_BAD_LO) && (code <= fsf_pkg::PAIR_MODE_BAD_HI);
  endfunction : pair_mode_bad

  function automatic logic [5:0] out_mode_amps(input logic [3:0] code);
    out_mode_amps = (code != 4'h0) ? fsf_pkg::OUT_MODE_AMPS : 6'h00;
  endfunction : out_mode_amps

  function automatic logic [5:0] diag_amps(input logic [2:0] sel);
    diag_amps = (sel == 3'h0) ? 6'h00 : 6'(6'h01 << (sel - 3'h1));
  endfunction : diag_amps

  // ==========================================================================
  // detector synchronisation
  // ==========================================================================
  logic [7:0] det_sync;
  logic       ovv5_s;
  logic       ovv6_s;
  logic       main_uv_s;
  logic       out_uv_s;
  logic       shdn_s;
  logic       warn_hi_s;
  logic       warn_lo_s;
  logic       oc_s;

  fsf_sync #(.WIDTH(8)) u_det_sync (
    .clk  (clk),
    .rst  (rst),
    .din  ({ovv_input_five, ovv_input_six, main_supply_uv, output_supply_uv,
            therm_shdn_det, therm_above_warn, therm_below_release, overcurrent_det}),
    .dout (det_sync)
  );

  assign {ovv5_s, ovv6_s, main_uv_s, out_uv_s, shdn_s, warn_hi_s, warn_lo_s, oc_s} = det_sync;

  // ==========================================================================
  // level flags: overvoltage, undervoltage, thermal warning
  // ==========================================================================
  logic ovv_flag_ff;
  logic main_uv_ff;
  logic out_uv_ff;
  logic warn_ff;
  logic ovv5_dis_ff;
  logic ovv6_dis_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      ovv_flag_ff <= 1'b0;
      ovv5_dis_ff <= 1'b0;
      ovv6_dis_ff <= 1'b0;
      main_uv_ff  <= 1'b0;
      out_uv_ff   <= 1'b0;
    end else begin
      ovv_flag_ff <= ovv5_s | ovv6_s;
      ovv5_dis_ff <= ovv5_s;
      ovv6_dis_ff <= ovv6_s;
      main_uv_ff  <= main_uv_s;
      out_uv_ff   <= out_uv_s;
    end
  end

  // hysteresis: rise on the upper detector, fall only on the lower one
  always_ff @(posedge clk) begin
    if (rst) begin
      warn_ff <= 1'b0;
    end else if (warn_hi_s) begin
      warn_ff <= 1'b1;
    end else if (warn_lo_s) begin
      warn_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // sticky flags, diag conflict level and config error
  // ==========================================================================
  logic shdn_flag;
  logic oc_flag;
  logic bad_code_flag;
  logic amp_fix_flag;
  logic diag_conflict;
  logic cfg_err_flag;
  logic bad_code_wr;
  logic [5:0] amp_missing;

  // set has priority over the clearing read
  fsf_sticky u_shdn (
    .clk  (clk),
    .rst  (rst),
    .set  (shdn_s),
    .clr  (status_rd),
    .flag (shdn_flag)
  );

  // auto mode clears as the condition ends, host mode on read
  fsf_sticky u_oc (
    .clk  (clk),
    .rst  (rst),
    .set  (oc_s),
    .clr  (overcurrent_clear_mode ? status_rd : ~oc_s),
    .flag (oc_flag)
  );

  assign bad_code_wr = cfg_wr & (out_mode_bad(wr_output_mode_code)
                                 | pair_mode_bad(wr_input_pair_a_mode_code)
                                 | pair_mode_bad(wr_input_pair_b_mode_code));

  fsf_sticky u_bad_code (
    .clk  (clk),
    .rst  (rst),
    .set  (bad_code_wr),
    .clr  (status_rd),
    .flag (bad_code_flag)
  );

  assign amp_missing = out_mode_amps(output_mode_code) & ~amp_power;

  fsf_sticky u_amp_fix (
    .clk  (clk),
    .rst  (rst),
    .set  (|amp_missing),
    .clr  (status_rd),
    .flag (amp_fix_flag)
  );

  assign diag_conflict = |(diag_amps(diag_channel_select) & ~amp_power);
  assign cfg_err_flag  = bad_code_flag | amp_fix_flag | diag_conflict;

  // ==========================================================================
  // configuration state
  // ==========================================================================
  logic [3:0] out_mode_ff;
  logic [2:0] pair_a_ff;
  logic [2:0] pair_b_ff;
  logic [5:0] amp_pwr_ff;
  logic [2:0] diag_sel_ff;
  logic       oc_mode_ff;
  logic       crc_en_ff;
  logic       dac_ref_ff;
  logic       adc_ref_ff;
  logic [7:0] chan_ctrl_ff;
  logic [5:0] nxt_amp_pwr;

  assign nxt_amp_pwr = (cfg_wr ? wr_amp_power : amp_pwr_ff) | amp_missing;

  // thermal shutdown returns everything to defaults but crc and refs
  always_ff @(posedge clk) begin
    if (rst || shdn_s) begin
      out_mode_ff  <= fsf_pkg::OUT_MODE_RESET;
      pair_a_ff    <= fsf_pkg::PAIR_MODE_RESET;
      pair_b_ff    <= fsf_pkg::PAIR_MODE_RESET;
      amp_pwr_ff   <= fsf_pkg::AMP_POWER_RESET;
      diag_sel_ff  <= fsf_pkg::DIAG_SEL_RESET;
      oc_mode_ff   <= fsf_pkg::OC_MODE_RESET;
      chan_ctrl_ff <= fsf_pkg::CHAN_CTRL_RESET;
    end else begin
      amp_pwr_ff <= nxt_amp_pwr;
      if (cfg_wr) begin
        if (!out_mode_bad(wr_output_mode_code)) begin
          out_mode_ff <= wr_output_mode_code;
        end
        if (!pair_mode_bad(wr_input_pair_a_mode_code)) begin
          pair_a_ff <= wr_input_pair_a_mode_code;
        end
        if (!pair_mode_bad(wr_input_pair_b_mode_code)) begin
          pair_b_ff <= wr_input_pair_b_mode_code;
        end
        diag_sel_ff <= wr_diag_channel_select;
        oc_mode_ff  <= wr_overcurrent_clear_mode;
      end
      if (chan_wr) begin
        chan_ctrl_ff <= wr_channel_control;
      end
    end
  end

  // crc enable and converter references survive a thermal shutdown
  always_ff @(posedge clk) begin
    if (rst) begin
      crc_en_ff  <= fsf_pkg::CRC_EN_RESET;
      dac_ref_ff <= fsf_pkg::REF_SEL_RESET;
      adc_ref_ff <= fsf_pkg::REF_SEL_RESET;
    end else if (cfg_wr) begin
      crc_en_ff  <= wr_crc_enable;
      dac_ref_ff <= wr_output_converter_ref_select;
      adc_ref_ff <= wr_input_converter_ref_select;
    end
  end

  // ==========================================================================
  // status read data
  // ==========================================================================
  logic [23:0] rdata_ff;
  logic [23:0] status_now;

  always_comb begin
    status_now = fsf_pkg::STATUS_RESET;
    status_now[fsf_pkg::BIT_AMP_OVV]    = ovv_flag_ff;
    status_now[fsf_pkg::BIT_MAIN_UV]    = main_uv_ff;
    status_now[fsf_pkg::BIT_OUT_UV]     = out_uv_ff;
    status_now[fsf_pkg::BIT_THERM_SHDN] = shdn_flag;
    status_now[fsf_pkg::BIT_THERM_WARN] = warn_ff;
    status_now[fsf_pkg::BIT_OVERCUR]    = oc_flag;
    status_now[fsf_pkg::BIT_CFG_ERR]    = cfg_err_flag;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff <= fsf_pkg::STATUS_RESET;
    end else if (status_rd) begin
      rdata_ff <= status_now;
    end
  end

  assign status_rdata                = rdata_ff;
  assign output_mode_code            = out_mode_ff;
  assign input_pair_a_mode_code      = pair_a_ff;
  assign input_pair_b_mode_code      = pair_b_ff;
  assign amp_power                   = amp_pwr_ff;
  assign diag_channel_select         = diag_sel_ff;
  assign overcurrent_clear_mode      = oc_mode_ff;
  assign crc_enable                  = crc_en_ff;
  assign output_converter_ref_select = dac_ref_ff;
  assign input_converter_ref_select  = adc_ref_ff;
  assign channel_control_register    = chan_ctrl_ff;
  assign input_five_disconnect       = ovv5_dis_ff;
  assign input_six_disconnect        = ovv6_dis_ff;

  // ==========================================================================
  // checks
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_ovv_follows: assert property (ovv_flag_ff == $past(ovv5_s | ovv6_s))
    else $error("amp overvoltage flag does not follow detectors");
  chk_disconnect_tied: assert property (ovv_flag_ff == (ovv5_dis_ff | ovv6_dis_ff))
    else $error("disconnect outputs disagree with overvoltage flag");
  chk_uv_follows: assert property (main_uv_ff == $past(main_uv_s)
                                   && out_uv_ff == $past(out_uv_s))
    else $error("undervoltage flag does not follow detector");
  chk_shdn_sets: assert property (shdn_s |=> shdn_flag)
    else $error("thermal shutdown flag not set");
  chk_shdn_defaults: assert property (shdn_s |=> out_mode_ff == fsf_pkg::OUT_MODE_RESET
                                      && chan_ctrl_ff == fsf_pkg::CHAN_CTRL_RESET
                                      && (crc_en_ff == $past(crc_en_ff) || $past(cfg_wr)))
    else $error("thermal shutdown did not restore defaults");
  chk_shdn_read_clr: assert property (status_rd && !shdn_s |=> !shdn_flag)
    else $error("thermal shutdown flag not cleared by read");
  chk_warn_hold: assert property (warn_ff && !warn_lo_s |=> warn_ff)
    else $error("thermal warning dropped without release");
  chk_oc_auto: assert property (!oc_mode_ff && !oc_s |=> !oc_flag)
    else $error("overcurrent flag not auto cleared");
  chk_oc_host: assert property (oc_mode_ff && oc_flag && !status_rd |=> oc_flag)
    else $error("overcurrent flag cleared without read in host mode");
  chk_bad_out_keep: assert property (cfg_wr && out_mode_bad(wr_output_mode_code)
                                     && !shdn_s |=> $stable(out_mode_ff) && cfg_err_flag)
    else $error("illegal output mode accepted or no error flagged");
  chk_amp_powerup: assert property (|amp_missing && !shdn_s |=> amp_fix_flag
                                    && ((amp_pwr_ff & $past(amp_missing)) == $past(amp_missing)))
    else $error("missing amps not powered up");
  chk_diag_hold: assert property (diag_conflict |-> cfg_err_flag)
    else $error("diag conflict not flagged");

  cov_shdn_read: cover property (shdn_flag && status_rd);
  cov_bad_code: cover property (bad_code_wr ##2 status_rd);
  cov_oc_host: cover property ((oc_mode_ff && oc_flag && !oc_s) ##1 status_rd);

endmodule : fsf_flags

/* fsf_pkg.sv */
/*
  Package for the fault and status flag block: bit positions of the general
  interrupt status register, configuration field widths, reset values and
  the illegal mode code ranges.
  Assumes nothing of its surroundings; imported by name only.
*/
package fsf_pkg;

  // ==========================================================================
  // general interrupt status register layout
  // ==========================================================================
  localparam int unsigned STATUS_W       = 24;
  localparam int unsigned BIT_AMP_OVV    = 8;
  localparam int unsigned BIT_MAIN_UV    = 7;
  localparam int unsigned BIT_OUT_UV     = 6;
  localparam int unsigned BIT_THERM_SHDN = 5;
  localparam int unsigned BIT_THERM_WARN = 4;
  localparam int unsigned BIT_OVERCUR    = 3;
  localparam int unsigned BIT_CFG_ERR    = 2;
  localparam logic [23:0] STATUS_RESET   = 24'h000000;

  // ==========================================================================
  // configuration fields
  // ==========================================================================
  localparam int unsigned OUT_MODE_W  = 4;
  localparam int unsigned PAIR_MODE_W = 3;
  localparam int unsigned AMP_N       = 6;
  localparam int unsigned DIAG_SEL_W  = 3;
  localparam int unsigned CHAN_CTRL_W = 8;

  localparam logic [3:0] OUT_MODE_RESET   = 4'h0;
  localparam logic [2:0] PAIR_MODE_RESET  = 3'h0;
  localparam logic [2:0] DIAG_SEL_RESET   = 3'h0;
  localparam logic [5:0] AMP_POWER_RESET  = 6'h00;
  localparam logic [7:0] CHAN_CTRL_RESET  = 8'h00;
  localparam logic       OC_MODE_RESET    = 1'b0;
  localparam logic       CRC_EN_RESET     = 1'b0;
  localparam logic       REF_SEL_RESET    = 1'b0;

  // illegal code ranges
  localparam logic [3:0] OUT_MODE_BAD_LO  = 4'h9;
  localparam logic [3:0] OUT_MODE_BAD_HI  = 4'hf;
  localparam logic [2:0] PAIR_MODE_BAD_LO = 3'h5;
  localparam logic [2:0] PAIR_MODE_BAD_HI = 3'h7;

  // amplifiers that an active output mode relies on (pair a inputs)
  localparam logic [5:0] OUT_MODE_AMPS    = 6'h03;

  // ==========================================================================
  // detector synchroniser depth
  // ==========================================================================
  localparam int unsigned SYNC_STAGES = 3;

endpackage : fsf_pkg

/* fsf_sticky.sv */
/*
  Sticky flag cell: set by an event, cleared by a clear strobe, with the
  set winning when both arrive in one cycle.
  Assumes set and clear come from logic on the same clock.
*/
module fsf_sticky (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic set,
  input  wire logic clr,
  output logic      flag
);

  logic flag_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      flag_ff <= 1'b0;
    end else if (set) begin
      flag_ff <= 1'b1;
    end else if (clr) begin
      flag_ff <= 1'b0;
    end
  end

  assign flag = flag_ff;

endmodule : fsf_sticky

/* fsf_sync.sv */
/*
  Three-stage input synchroniser with an agree filter: the output follows
  the input once the second and third stages agree.
  Assumes raw inputs from outside the clock domain; one clock, sync reset.
*/
module fsf_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] out_ff;

  if (WIDTH < 1) begin : g_bad_width
    $error("fsf_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // per bit: take the new level only when stages two and three agree
  always_ff @(posedge clk) begin
    if (rst) begin
      out_ff <= '0;
    end else begin
      out_ff <= (out_ff & (s2_ff ^ s3_ff)) | (s3_ff & ~(s2_ff ^ s3_ff));
    end
  end

  assign dout = out_ff;

endmodule : fsf_sync

/* tb.sv */
/*
  Self-checking bench for the fault and status flag block: detector levels,
  clear-on-read and sticky flags, thermal shutdown defaults, mode checks.
  Assumes the fsf_* design files are compiled first; one 40 MHz clock.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, rst, status_rd, cfg_wr, chan_wr;
  logic        ovv5, ovv6, muv, ouv, tsd, tabove, tbelow, ocd;
  logic [23:0] rdata, v;
  logic [3:0]  w_om, om;
  logic [2:0]  w_pa, w_pb, w_dg, pa, pb, dg, rpa, rpb;
  logic [5:0]  w_amp, amp;
  logic        w_ocm, w_crc, w_orf, w_irf, ocm, crc, orf, irf, dis5, dis6;
  logic [7:0]  w_ch, ch;
  logic [31:0] seed;
  int          error_cnt, num_checks;
  int          bt [4] = '{8, 8, 7, 6};

  fsf_flags dut_u (
    .clk(clk), .rst(rst), .ovv_input_five(ovv5), .ovv_input_six(ovv6),
    .main_supply_uv(muv), .output_supply_uv(ouv), .therm_shdn_det(tsd),
    .therm_above_warn(tabove), .therm_below_release(tbelow), .overcurrent_det(ocd),
    .status_rd(status_rd), .status_rdata(rdata), .cfg_wr(cfg_wr),
    .wr_output_mode_code(w_om), .wr_input_pair_a_mode_code(w_pa),
    .wr_input_pair_b_mode_code(w_pb), .wr_amp_power(w_amp),
    .wr_diag_channel_select(w_dg), .wr_overcurrent_clear_mode(w_ocm),
    .wr_crc_enable(w_crc), .wr_output_converter_ref_select(w_orf),
    .wr_input_converter_ref_select(w_irf), .chan_wr(chan_wr), .wr_channel_control(w_ch),
    .output_mode_code(om), .input_pair_a_mode_code(pa), .input_pair_b_mode_code(pb),
    .amp_power(amp), .diag_channel_select(dg), .overcurrent_clear_mode(ocm),
    .crc_enable(crc), .output_converter_ref_select(orf),
    .input_converter_ref_select(irf), .channel_control_register(ch),
    .input_five_disconnect(dis5), .input_six_disconnect(dis6)
  );

  // ==========================================================================
  // helpers
  // ==========================================================================
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  // amplifiers expected after a write: requested ones plus those the output mode needs
  function automatic logic [5:0] ea(input logic [3:0] o, input logic [5:0] p);
    return p | ((o != 4'h0) ? fsf_pkg::OUT_MODE_AMPS : 6'h00);
  endfunction : ea

  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  task automatic rd();
    @(posedge clk) status_rd <= 1'b1;
    @(posedge clk) status_rd <= 1'b0;
    @(negedge clk) v = rdata;
    chk("reserved bits", 24'h0, v & 24'hfffe03);
  endtask : rd

  task automatic bit_is(input int b, input logic e, input string nm);
    rd();
    chk(nm, {23'h0, e}, {23'h0, v[b]});
  endtask : bit_is

  // bounded poll of one status bit; running out ends the run
  task automatic poll(input int b, input logic e, input string nm);
    for (int i = 0; i < 30; i++) begin
      rd();
      if (v[b] === e) break;
    end
    chk(nm, {23'h0, e}, {23'h0, v[b]});
    if (v[b] !== e) give_verdict();
  endtask : poll

  task automatic lvl(input int i, input logic x);
    @(posedge clk) begin
      case (i)
        0: ovv5 <= x;
        1: ovv6 <= x;
        2: muv <= x;
        default: ouv <= x;
      endcase
    end
  endtask : lvl

  task automatic cfg(input logic [3:0] o, input logic [2:0] a, input logic [2:0] b,
                     input logic [2:0] d, input logic [5:0] p, input logic m, input logic c);
    @(posedge clk) begin
      cfg_wr <= 1'b1;
      w_om <= o;
      w_pa <= a;
      w_pb <= b;
      w_dg <= d;
      w_amp <= p;
      w_ocm <= m;
      w_crc <= c;
      w_orf <= c;
      w_irf <= c;
    end
    @(posedge clk) cfg_wr <= 1'b0;
    @(negedge clk);
  endtask : cfg

  task automatic chw(input logic [7:0] x);
    @(posedge clk) begin
      chan_wr <= 1'b1;
      w_ch <= x;
    end
    @(posedge clk) chan_wr <= 1'b0;
    @(negedge clk);
  endtask : chw

  // ==========================================================================
  // clock and main sequence
  // ==========================================================================
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    {rst, status_rd, cfg_wr, chan_wr, ovv5, ovv6, muv, ouv} = 8'hff;
    {status_rd, cfg_wr, chan_wr, ovv5, ovv6, muv, ouv} = 7'h0;
    {tsd, tabove, tbelow, ocd, w_ocm, w_crc, w_orf, w_irf} = 8'h0;
    {w_om, w_pa, w_pb, w_dg, w_amp, w_ch} = 27'h0;
    error_cnt = 0;
    num_checks = 0;
    seed = 32'h40;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd();
    chk("status after reset", 24'h0, v);
    for (int i = 0; i < 4; i++) begin
      lvl(i, 1'b1);
      poll(bt[i], 1'b1, "level flag set");
      if (i < 2) chk("disconnect", {22'h0, i == 1, i == 0}, {22'h0, dis6, dis5});
      lvl(i, 1'b0);
      poll(bt[i], 1'b0, "level flag clear");
      chk("reconnect", 24'h0, {22'h0, dis6, dis5});
    end
    $display("test level flags done");
    @(posedge clk) tabove <= 1'b1;
    poll(4, 1'b1, "warning set");
    @(posedge clk) tabove <= 1'b0;
    repeat (10) @(posedge clk);
    bit_is(4, 1'b1, "warning held");
    @(posedge clk) tbelow <= 1'b1;
    poll(4, 1'b0, "warning clear");
    @(posedge clk) tbelow <= 1'b0;
    $display("test thermal warning done");
    seed = xs(seed);
    rpa = seed[2:0] % 3'h5;
    rpb = seed[5:3] % 3'h5;
    cfg(4'h1, rpa, rpb, 3'h0, 6'h3f, 1'b1, 1'b1);
    chw(seed[15:8]);
    chk("written", {seed[15:8], 9'h0, 1'b1, rpa, rpb}, {ch, 9'h0, ocm, pa, pb});
    @(posedge clk) tsd <= 1'b1;
    poll(5, 1'b1, "shutdown set");
    chk("shutdown config", 24'h7, {1'b0, om, pa, pb, amp, dg, ocm, crc, orf, irf});
    chk("shutdown channel", 24'h0, {16'h0, ch});
    bit_is(5, 1'b1, "shutdown read while hot");
    @(posedge clk) tsd <= 1'b0;
    repeat (8) @(posedge clk);
    bit_is(5, 1'b1, "shutdown sticky");
    bit_is(5, 1'b0, "shutdown read clear");
    $display("test thermal shutdown done");
    @(posedge clk) ocd <= 1'b1;
    poll(3, 1'b1, "overcurrent set");
    @(posedge clk) ocd <= 1'b0;
    poll(3, 1'b0, "overcurrent auto clear");
    cfg(4'h0, rpa, rpb, 3'h0, 6'h00, 1'b1, 1'b0);
    @(posedge clk) ocd <= 1'b1;
    poll(3, 1'b1, "overcurrent host set");
    bit_is(3, 1'b1, "overcurrent read while active");
    @(posedge clk) ocd <= 1'b0;
    repeat (8) @(posedge clk);
    bit_is(3, 1'b1, "overcurrent held");
    bit_is(3, 1'b0, "overcurrent read clear");
    $display("test overcurrent done");
    cfg(4'h2, rpa, rpb, 3'h0, 6'h03, 1'b0, 1'b0);
    for (int k = 0; k < 13; k++) begin
      cfg((k < 7) ? 4'(k + 9) : 4'h2, (k > 6 && k < 10) ? 3'(k - 2) : rpa,
          (k > 9) ? 3'(k - 5) : rpb, 3'h0, 6'h03, 1'b0, 1'b0);
      chk("modes kept", {14'h0, 4'h2, rpa, rpb}, {14'h0, om, pa, pb});
      bit_is(2, 1'b1, "mode error set");
      bit_is(2, 1'b0, "mode error read clear");
    end
    $display("test illegal modes done");
    cfg(4'h3, rpa, rpb, 3'h0, 6'h00, 1'b0, 1'b0);
    // the amp power-up lands one cycle after the mode itself
    @(negedge clk);
    chk("amps powered", {18'h0, ea(4'h3, 6'h00)}, {18'h0, amp});
    bit_is(2, 1'b1, "amp error set");
    bit_is(2, 1'b0, "amp error read clear");
    cfg(4'h0, rpa, rpb, 3'h3, 6'h00, 1'b0, 1'b0);
    bit_is(2, 1'b1, "diag error set");
    bit_is(2, 1'b1, "diag error survives read");
    cfg(4'h0, rpa, rpb, 3'h3, 6'h04, 1'b0, 1'b0);
    rd();
    bit_is(2, 1'b0, "diag error resolved");
    $display("test configuration errors done");
    give_verdict();
  end

endmodule : tb
